/* File: hw/ext_reg_decode.sv */
// Host I/O register decoder with locked extension register groups.
// Assumes host requests come from logic on core_clk, one-cycle rd/wr strobes;
// strap and sense pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "ext_reg_decode_map.svh"

module ext_reg_decode
   import ext_reg_decode_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire io_req_t io_req,
   output io_rsp_t io_rsp,
   input wire logic [15:0] strap_pins,
   input wire logic [7:0] sense_pins,
   input wire logic [15:0] engine_status,
   input wire logic [15:0] subsystem_status,
   output logic color_mode,
   output logic engine_enable,
   output logic [7:0] misc_output,
   output logic [7:0] video_subsystem_enable,
   output logic [15:0] subsystem_control,
   output logic [15:0] advanced_function_control,
   output logic [15:0] drawing_command,
   output logic drawing_command_stb,
   output logic [15:0] pixel_transfer,
   output logic pixel_transfer_stb
);

   // ****************************************
   // Reset release
   // ****************************************
   // Two-stage reset release
   logic rst_meta_b;
   logic rst_sync_b;

   // Whole decoder state, current and next
   state_t s_reg;
   state_t s_next;

   // Lock and port decode
   logic unlock_one_open;
   logic unlock_two_open;
   logic [15:0] crt_index_port;
   logic [15:0] crt_data_port;

   // CRT data path
   logic [7:0] crt_rd;
   logic crt_wr_ok;

   // Multifunction write steering
   logic [3:0] multi_slot_code;
   logic [3:0] multi_wr_index;
   logic [2:0] multi_wr_slot;
   logic multi_wr_valid;

   // Read answer before registering
   logic [15:0] rd_word;
   logic hit;

   // Asserted asynchronously, released only after two clean edges
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   // Byte-lane merge for the 16-bit engine ports
   function automatic logic [15:0] lane_merge(
      input logic [15:0] old,
      input logic [15:0] wd,
      input logic [1:0] be
   );
      // Lanes left out keep their stored byte
      lane_merge = old;
      if (be[0]) begin
         lane_merge[7:0] = wd[7:0];
      end
      if (be[1]) begin
         lane_merge[15:8] = wd[15:8];
      end
   endfunction

   // Multifunction index to storage slot; only 0-4, A, E, F exist
   function automatic logic [3:0] multi_slot(input logic [3:0] idx);
      // Codes 8-f carry slots 0-7; code 0 means no storage
      case (idx)
         4'h0: multi_slot = 4'h8;
         4'h1: multi_slot = 4'h9;
         4'h2: multi_slot = 4'ha;
         4'h3: multi_slot = 4'hb;
         4'h4: multi_slot = 4'hc;
         4'ha: multi_slot = 4'hd;
         4'he: multi_slot = 4'he;
         4'hf: multi_slot = 4'hf;
         default: multi_slot = 4'h0;
      endcase
   endfunction

   // ****************************************
   // Lock state and port selection
   // ****************************************
   // Pure compare on the held key: only a new key write or reset relocks
   assign unlock_one_open = (s_reg.unlock_one == `UNLOCK_ONE_KEY);
   assign unlock_two_open = (s_reg.unlock_two == `UNLOCK_TWO_KEY);

   // Mode bits are plain registers; reset leaves the mono ports
   assign color_mode = s_reg.misc_output[`MISC_COLOR_BIT];
   assign engine_enable = s_reg.ext2[0][`SYS_CONFIG_ENGINE_BIT];
   assign crt_index_port = color_mode ? `PORT_CRT_INDEX_COLOR : `PORT_CRT_INDEX_MONO;
   assign crt_data_port = color_mode ? `PORT_CRT_DATA_COLOR : `PORT_CRT_DATA_MONO;

   // Low-byte-only writes steer by the last latched index
   assign multi_wr_index = io_req.be[1] ? io_req.wdata[15:12] : s_reg.multi_index;
   // Bit 3 of the slot code marks an index with storage
   assign multi_slot_code = multi_slot(multi_wr_index);
   assign multi_wr_valid = multi_slot_code[3];
   assign multi_wr_slot = multi_slot_code[2:0];

   // ****************************************
   // CRT data read path and write permission
   // ****************************************
   // Locked groups read as zero so no extension state leaks out
   always_comb begin
      crt_rd = 8'h00;
      crt_wr_ok = 1'b0;
      if (s_reg.crt_index <= `CRT_STD_LAST) begin
         // Standard timing registers, always open
         crt_rd = s_reg.crt_std[5'(s_reg.crt_index)];
         crt_wr_ok = 1'b1;
      end else if (s_reg.crt_index == `UNLOCK_ONE_INDEX) begin
         crt_rd = s_reg.unlock_one;
         crt_wr_ok = 1'b1;
      end else if (s_reg.crt_index == `UNLOCK_TWO_INDEX) begin
         crt_rd = s_reg.unlock_two;
         crt_wr_ok = 1'b1;
      end else if (s_reg.crt_index == `CHIP_IDENTITY_INDEX) begin
         crt_rd = unlock_one_open ? `CHIP_IDENTITY_VALUE : 8'h00;
      end else if (s_reg.crt_index == `CONFIG_ONE_INDEX) begin
         crt_rd = unlock_one_open ? s_reg.config_one : 8'h00;
      end else if (s_reg.crt_index == `CONFIG_TWO_INDEX) begin
         crt_rd = unlock_one_open ? s_reg.config_two : 8'h00;
      end else if (s_reg.crt_index >= `EXT1_FIRST_INDEX && s_reg.crt_index <= `EXT1_LAST_INDEX) begin
         // Remaining group one indices, plain storage
         crt_rd = unlock_one_open ? s_reg.ext1[4'(s_reg.crt_index - `EXT1_FIRST_INDEX)] : 8'h00;
         crt_wr_ok = unlock_one_open;
      end else if (s_reg.crt_index >= `SYS_CONFIG_INDEX && s_reg.crt_index <= `EXT2_LAST_INDEX) begin
         crt_rd = unlock_two_open ? s_reg.ext2[5'(s_reg.crt_index - `SYS_CONFIG_INDEX)] : 8'h00;
         crt_wr_ok = unlock_two_open;
      end
   end

   // ****************************************
   // Host read decode
   // ****************************************
   // Engine ports vanish from the map while the engine is disabled
   always_comb begin
      rd_word = `UNMAPPED_READ;
      hit = 1'b1;
      if (io_req.addr == `PORT_MISC_STATUS) begin
         // Input status from the synchronised sense pins
         rd_word = {8'h00, s_reg.sense_s2};
      end else if (io_req.addr == `PORT_MISC_READ) begin
         rd_word = {8'h00, s_reg.misc_output};
      end else if (io_req.addr == `PORT_SETUP_OPTION) begin
         rd_word = {8'h00, s_reg.setup_option};
      end else if (io_req.addr == `PORT_SEQ_INDEX) begin
         rd_word = {8'h00, s_reg.seq_index};
      end else if (io_req.addr == `PORT_SEQUENCER_DATA) begin
         rd_word = (s_reg.seq_index < 8'(`SEQ_COUNT)) ? {8'h00, s_reg.sequencer_data[3'(s_reg.seq_index)]} : 16'h0000;
      end else if (io_req.addr == crt_index_port) begin
         rd_word = {8'h00, s_reg.crt_index};
      end else if (io_req.addr == crt_data_port) begin
         rd_word = {8'h00, crt_rd};
      end else if (io_req.addr == `PORT_VIDEO_ENABLE) begin
         hit = io_req.wr;
      end else if (engine_enable && io_req.addr == `PORT_SUBSYS) begin
         rd_word = subsystem_status;
      end else if (engine_enable && io_req.addr == `PORT_ADV_FUNC) begin
         rd_word = s_reg.adv_func;
      end else if (engine_enable && io_req.addr == `PORT_ENGINE_CMD) begin
         rd_word = engine_status;
      end else if (engine_enable && io_req.addr == `PORT_MULTIFUNC) begin
         // Read select chooses one of the eight slots
         rd_word = {4'h0, s_reg.multi_regs[s_reg.multi_regs[`MULTI_READ_SELECT_SLOT][2:0]]};
      end else if (engine_enable && io_req.addr == `PORT_PIXEL) begin
         rd_word = s_reg.pixel;
      end else if (engine_enable && io_req.addr == `PORT_PIXEL_EXT) begin
         rd_word = s_reg.pixel_ext;
      end else begin
         hit = 1'b0;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   // Hold all state; one-cycle pulses drop unless renewed
   always_comb begin
      s_next = s_reg;
      s_next.command_stb = 1'b0;
      s_next.pixel_stb = 1'b0;
      s_next.rd_valid = 1'b0;

      // Pins cross into core_clk through two stages
      s_next.strap_s1 = strap_pins;
      s_next.strap_s2 = s_reg.strap_s1;
      s_next.sense_s1 = sense_pins;
      s_next.sense_s2 = s_reg.sense_s1;

      // Straps captured once, after the synchroniser has filled
      if (!s_reg.strap_done) begin
         if (s_reg.settle_cnt == `STRAP_SETTLE_CYCLES) begin
            s_next.config_one = s_reg.strap_s2[7:0];
            s_next.config_two = s_reg.strap_s2[15:8];
            s_next.strap_done = 1'b1;
         end else begin
            s_next.settle_cnt = s_reg.settle_cnt + 2'h1;
         end
      end

      // Read answer registered one cycle after the strobe
      if (io_req.rd) begin
         s_next.rd_valid = 1'b1;
         s_next.rdata = rd_word;
      end

      // Writes
      if (io_req.wr) begin
         if (io_req.addr == `PORT_MISC_STATUS) begin
            s_next.misc_output = io_req.wdata[7:0];
         end else if (io_req.addr == `PORT_SETUP_OPTION) begin
            s_next.setup_option = io_req.wdata[7:0];
         end else if (io_req.addr == `PORT_SEQ_INDEX) begin
            s_next.seq_index = io_req.wdata[7:0];
         end else if (io_req.addr == `PORT_SEQUENCER_DATA) begin
            // Indices past the five data registers are dropped
            if (s_reg.seq_index < 8'(`SEQ_COUNT)) begin
               s_next.sequencer_data[3'(s_reg.seq_index)] = io_req.wdata[7:0];
            end
         end else if (io_req.addr == crt_index_port) begin
            s_next.crt_index = io_req.wdata[7:0];
         end else if (io_req.addr == crt_data_port && crt_wr_ok) begin
            // Read-only and locked indices never reach storage
            if (s_reg.crt_index <= `CRT_STD_LAST) begin
               s_next.crt_std[5'(s_reg.crt_index)] = io_req.wdata[7:0];
            end else if (s_reg.crt_index == `UNLOCK_ONE_INDEX) begin
               s_next.unlock_one = io_req.wdata[7:0];
            end else if (s_reg.crt_index == `UNLOCK_TWO_INDEX) begin
               s_next.unlock_two = io_req.wdata[7:0];
            end else if (s_reg.crt_index <= `EXT1_LAST_INDEX) begin
               s_next.ext1[4'(s_reg.crt_index - `EXT1_FIRST_INDEX)] = io_req.wdata[7:0];
            end else begin
               s_next.ext2[5'(s_reg.crt_index - `SYS_CONFIG_INDEX)] = io_req.wdata[7:0];
            end
         end else if (io_req.addr == `PORT_VIDEO_ENABLE) begin
            s_next.video_enable = io_req.wdata[7:0];
         end else if (engine_enable) begin
            // Engine ports take writes only while enabled
            if (io_req.addr == `PORT_SUBSYS) begin
               s_next.subsystem_control = lane_merge(s_reg.subsystem_control, io_req.wdata, io_req.be);
            end else if (io_req.addr == `PORT_ADV_FUNC) begin
               s_next.adv_func = lane_merge(s_reg.adv_func, io_req.wdata, io_req.be);
            end else if (io_req.addr == `PORT_ENGINE_CMD) begin
               s_next.command = lane_merge(s_reg.command, io_req.wdata, io_req.be);
               // Strobe pulses once per command write
               s_next.command_stb = 1'b1;
            end else if (io_req.addr == `PORT_MULTIFUNC) begin
               // High byte carries the index; a low byte alone reuses the last one
               if (io_req.be[1]) begin
                  s_next.multi_index = io_req.wdata[15:12];
               end
               if (multi_wr_valid) begin
                  if (io_req.be[1]) begin
                     s_next.multi_regs[multi_wr_slot][11:8] = io_req.wdata[11:8];
                  end
                  if (io_req.be[0]) begin
                     s_next.multi_regs[multi_wr_slot][7:0] = io_req.wdata[7:0];
                  end
               end
            end else if (io_req.addr == `PORT_PIXEL) begin
               s_next.pixel = lane_merge(s_reg.pixel, io_req.wdata, io_req.be);
               // Each pixel write pulses the transfer strobe
               s_next.pixel_stb = 1'b1;
            end else if (io_req.addr == `PORT_PIXEL_EXT) begin
               s_next.pixel_ext = lane_merge(s_reg.pixel_ext, io_req.wdata, io_req.be);
            end
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Reset clears both keys, so every extension group starts locked
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_reg <= '0;
      end else if (clk_en) begin
         // Low clk_en freezes all but the reset release
         s_reg <= s_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Data straight from state flops; hit stays combinational
   assign io_rsp.hit = hit;
   assign io_rsp.rd_valid = s_reg.rd_valid;
   assign io_rsp.rdata = s_reg.rdata;
   assign misc_output = s_reg.misc_output;
   assign video_subsystem_enable = s_reg.video_enable;
   assign subsystem_control = s_reg.subsystem_control;
   assign advanced_function_control = s_reg.adv_func;
   assign drawing_command = s_reg.command;
   assign drawing_command_stb = s_reg.command_stb;
   assign pixel_transfer = s_reg.pixel;
   assign pixel_transfer_stb = s_reg.pixel_stb;

endmodule // ext_reg_decode

/* File: inc/ext_reg_decode_map.svh */
// Port addresses, indices, keys, unmapped read value and timing counts of the host register decoder.
// Assumes 16-bit host I/O addresses and 8-bit CRT controller indices.
`ifndef EXT_REG_DECODE_MAP_SVH
`define EXT_REG_DECODE_MAP_SVH

// ****************************************
// Host I/O port addresses
// ****************************************
`define PORT_SETUP_OPTION 16'h0102
`define PORT_MISC_STATUS 16'h03c2
`define PORT_MISC_READ 16'h03cc
`define PORT_SEQ_INDEX 16'h03c4
`define PORT_SEQUENCER_DATA 16'h03c5
`define PORT_CRT_INDEX_MONO 16'h03b4
`define PORT_CRT_DATA_MONO 16'h03b5
`define PORT_CRT_INDEX_COLOR 16'h03d4
`define PORT_CRT_DATA_COLOR 16'h03d5
`define PORT_SUBSYS 16'h42e8
`define PORT_VIDEO_ENABLE 16'h46e8
`define PORT_ADV_FUNC 16'h4ae8
`define PORT_ENGINE_CMD 16'h9ae8
`define PORT_MULTIFUNC 16'hbee8
`define PORT_PIXEL 16'he2e8
`define PORT_PIXEL_EXT 16'he2ea

// ****************************************
// CRT controller indices
// ****************************************
`define CRT_STD_LAST 8'h18
`define CRT_STD_COUNT 25
`define CHIP_IDENTITY_INDEX 8'h30
`define EXT1_FIRST_INDEX 8'h31
`define EXT1_LAST_INDEX 8'h3c
`define CONFIG_ONE_INDEX 8'h36
`define CONFIG_TWO_INDEX 8'h37
`define UNLOCK_ONE_INDEX 8'h38
`define UNLOCK_TWO_INDEX 8'h39
`define SYS_CONFIG_INDEX 8'h40
`define EXT2_LAST_INDEX 8'h5f
`define SEQ_COUNT 5

// ****************************************
// Keys, identity, field positions, unmapped read value
// ****************************************
`define UNLOCK_ONE_KEY 8'h5a
`define UNLOCK_TWO_KEY 8'hc3
`define CHIP_IDENTITY_VALUE 8'h11
`define SYS_CONFIG_ENGINE_BIT 0
`define MISC_COLOR_BIT 0
`define MULTI_READ_SELECT_SLOT 3'h7
`define UNMAPPED_READ 16'hffff
`define STRAP_SETTLE_CYCLES 2'h2

`endif

/* File: inc/ext_reg_decode_pkg.sv */
// Types shared by the host register decoder.
// Assumes the constants header is on the include path; its counts size the state.
`include "ext_reg_decode_map.svh"
package ext_reg_decode_pkg;

   // ****************************************
   // Host I/O request and answer
   // ****************************************
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [1:0] be;
      logic [15:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic hit;
      logic rd_valid;
      logic [15:0] rdata;
   } io_rsp_t;

   // ****************************************
   // Whole state of the decoder
   // ****************************************
   typedef struct packed {
      logic [15:0] strap_s1;
      logic [15:0] strap_s2;
      logic [7:0] sense_s1;
      logic [7:0] sense_s2;
      logic [1:0] settle_cnt;
      logic strap_done;
      logic [7:0] config_one;
      logic [7:0] config_two;
      logic [7:0] misc_output;
      logic [7:0] setup_option;
      logic [7:0] video_enable;
      logic [7:0] seq_index;
      logic [`SEQ_COUNT-1:0][7:0] sequencer_data;
      logic [7:0] crt_index;
      logic [`CRT_STD_COUNT-1:0][7:0] crt_std;
      logic [11:0][7:0] ext1;
      logic [7:0] unlock_one;
      logic [7:0] unlock_two;
      logic [31:0][7:0] ext2;
      logic [15:0] subsystem_control;
      logic [15:0] adv_func;
      logic [15:0] command;
      logic command_stb;
      logic [3:0] multi_index;
      logic [7:0][11:0] multi_regs;
      logic [15:0] pixel;
      logic [15:0] pixel_ext;
      logic pixel_stb;
      logic rd_valid;
      logic [15:0] rdata;
   } state_t;

endpackage

/* File: dv/ext_reg_decode_properties.sv */
// Concurrent checks on the ports of the host register decoder.
// Assumes one-cycle rd/wr strobes on core_clk and the constants header on the include path.
`timescale 1ns/1ps
`include "ext_reg_decode_map.svh"

module ext_reg_decode_properties
   import ext_reg_decode_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire io_req_t io_req,
   input wire io_rsp_t io_rsp,
   input wire logic [15:0] engine_status,
   input wire logic [15:0] subsystem_status,
   input wire logic color_mode,
   input wire logic engine_enable,
   input wire logic [7:0] misc_output,
   input wire logic [15:0] drawing_command,
   input wire logic drawing_command_stb
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // ****************************************
   // Request sequences
   // ****************************************
   // Only enabled edges count as taken requests
   sequence s_rd(a);
      clk_en && io_req.rd && io_req.addr == a;
   endsequence
   sequence s_wr(a);
      clk_en && io_req.wr && io_req.addr == a;
   endsequence

   // ****************************************
   // Assertions
   // ****************************************
   read_answer_a: assert property (clk_en && io_req.rd |=> io_rsp.rd_valid)
      else $error("read not answered next cycle");
   valid_cause_a: assert property (io_rsp.rd_valid |-> $past(clk_en && io_req.rd)
      || $past(!clk_en && io_rsp.rd_valid))
      else $error("read valid without a read");
   mono_ports_a: assert property (io_req.addr == `PORT_CRT_INDEX_COLOR && !color_mode |-> !io_rsp.hit)
      else $error("color index port decoded in mono mode");
   color_ports_a: assert property (io_req.addr == `PORT_CRT_INDEX_MONO && color_mode |-> !io_rsp.hit)
      else $error("mono index port decoded in color mode");
   misc_load_a: assert property (s_wr(`PORT_MISC_STATUS) |=> misc_output == $past(io_req.wdata[7:0]))
      else $error("misc output not loaded");
   engine_gate_a: assert property (!engine_enable && (io_req.addr == `PORT_ENGINE_CMD
      || io_req.addr == `PORT_SUBSYS || io_req.addr == `PORT_MULTIFUNC) |-> !io_rsp.hit)
      else $error("engine port decoded while disabled");
   engine_off_read_a: assert property (s_rd(`PORT_ENGINE_CMD) and !engine_enable
      |=> io_rsp.rdata == `UNMAPPED_READ)
      else $error("disabled engine port answered");
   command_load_a: assert property (s_wr(`PORT_ENGINE_CMD) and engine_enable && io_req.be == 2'h3
      |=> drawing_command_stb && drawing_command == $past(io_req.wdata))
      else $error("drawing command not taken");
   status_read_a: assert property (s_rd(`PORT_ENGINE_CMD) and engine_enable
      |=> io_rsp.rdata == $past(engine_status))
      else $error("engine status not returned");
   subsys_read_a: assert property (s_rd(`PORT_SUBSYS) and engine_enable
      |=> io_rsp.rdata == $past(subsystem_status))
      else $error("subsystem status not returned");
   vse_no_read_a: assert property (s_rd(`PORT_VIDEO_ENABLE) |=> io_rsp.rdata == `UNMAPPED_READ)
      else $error("write-only port returned data");
endmodule // ext_reg_decode_properties

bind ext_reg_decode ext_reg_decode_properties i_props (
   .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .io_req(io_req), .io_rsp(io_rsp),
   .engine_status(engine_status), .subsystem_status(subsystem_status), .color_mode(color_mode),
   .engine_enable(engine_enable), .misc_output(misc_output), .drawing_command(drawing_command),
   .drawing_command_stb(drawing_command_stb)
);

/* File: dv/host_model.sv */
// Host processor model issuing single I/O cycles to the decoder.
// Assumes the decoder samples requests on the rising edge; strobes launch at the falling edge.
`timescale 1ns/1ps

module host_model
   import ext_reg_decode_pkg::*;
(
   input wire logic core_clk,
   input wire io_rsp_t io_rsp,
   output io_req_t io_req
);
   // ****************************************
   // Bus cycles
   // ****************************************
   initial io_req = '0;

   // Key writes and byte-lane writes go through here; lines turned over after use
   task automatic io_wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
      @(negedge core_clk);
      io_req = '{addr: a, wr: 1'b1, rd: 1'b0, be: be, wdata: d};
      @(negedge core_clk);
      io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, be: ~be, wdata: ~d};
   endtask

   // Answer taken in the cycle after the read edge, while it stands
   task automatic io_rd(input logic [15:0] a, output logic [15:0] q, output logic v);
      @(negedge core_clk);
      io_req = '{addr: a, wr: 1'b0, rd: 1'b1, be: 2'h3, wdata: ~io_req.wdata};
      @(negedge core_clk);
      q = io_rsp.rdata;
      v = io_rsp.rd_valid;
      io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, be: 2'h0, wdata: ~io_req.wdata};
   endtask
endmodule // host_model

/* File: dv/tb_top.sv */
// Self-checking bench for the host register decoder: table of host cycles, then hand tests.
// Assumes host_model drives the request bus and the checker is bound to the decoder.
`timescale 1ns/1ps

module tb_top
   import ext_reg_decode_pkg::*;
;
   typedef struct packed {logic w; logic [15:0] a; logic [15:0] d; logic [1:0] be;} row_t;
   logic core_clk, rst_b, clk_en, color_mode, engine_enable, drawing_command_stb, pixel_transfer_stb, v;
   logic [15:0] strap_pins = 16'hb74c;
   logic [7:0] sense_pins = 8'h96;
   logic [15:0] engine_status = 16'h8421;
   logic [15:0] subsystem_status = 16'h0f3c;
   logic [7:0] misc_output, video_subsystem_enable;
   logic [15:0] subsystem_control, advanced_function_control, drawing_command, pixel_transfer, q;
   io_req_t io_req;
   io_rsp_t io_rsp;
   int n_tests = 0;
   int n_mismatch = 0;
   // Reads carry the expected data in d; mono ports until misc bit 0 is set
   row_t rows [48] = '{
      '{1'b1,16'h03b4,16'h0031,2'h3}, '{1'b1,16'h03b5,16'h00a5,2'h3}, '{1'b0,16'h03b5,16'h0000,2'h3},
      '{1'b1,16'h03b4,16'h0038,2'h3}, '{1'b1,16'h03b5,16'h005a,2'h3}, '{1'b1,16'h03b4,16'h0031,2'h3},
      '{1'b0,16'h03b5,16'h0000,2'h3}, '{1'b1,16'h03b5,16'h00a5,2'h3}, '{1'b0,16'h03b5,16'h00a5,2'h3},
      '{1'b1,16'h03b4,16'h0030,2'h3}, '{1'b1,16'h03b5,16'h00ff,2'h3}, '{1'b0,16'h03b5,16'h0011,2'h3},
      '{1'b1,16'h03b4,16'h0036,2'h3}, '{1'b0,16'h03b5,16'h004c,2'h3}, '{1'b1,16'h03b4,16'h0037,2'h3},
      '{1'b1,16'h03b5,16'h0000,2'h3}, '{1'b0,16'h03b5,16'h00b7,2'h3}, '{1'b1,16'h03b4,16'h0040,2'h3},
      '{1'b1,16'h03b5,16'h0001,2'h3}, '{1'b0,16'h03b5,16'h0000,2'h3}, '{1'b0,16'h9ae8,16'hffff,2'h3},
      '{1'b1,16'h03b4,16'h0039,2'h3}, '{1'b1,16'h03b5,16'h00c3,2'h3}, '{1'b1,16'h03b4,16'h0040,2'h3},
      '{1'b1,16'h03b5,16'h0001,2'h3}, '{1'b0,16'h03b5,16'h0001,2'h3}, '{1'b1,16'h03b4,16'h0055,2'h3},
      '{1'b1,16'h03b5,16'h003c,2'h3}, '{1'b0,16'h03b5,16'h003c,2'h3}, '{1'b0,16'h03d4,16'hffff,2'h3},
      '{1'b1,16'h03c2,16'h0001,2'h3}, '{1'b0,16'h03cc,16'h0001,2'h3}, '{1'b0,16'h03c2,16'h0096,2'h3},
      '{1'b0,16'h03d4,16'h0055,2'h3}, '{1'b0,16'h03b4,16'hffff,2'h3}, '{1'b1,16'h03d4,16'h0031,2'h3},
      '{1'b0,16'h03d5,16'h00a5,2'h3}, '{1'b0,16'h9ae8,16'h8421,2'h3}, '{1'b0,16'h42e8,16'h0f3c,2'h3},
      '{1'b1,16'hbee8,16'hf006,2'h3}, '{1'b1,16'hbee8,16'he123,2'h3}, '{1'b0,16'hbee8,16'h0123,2'h3},
      '{1'b1,16'hbee8,16'he500,2'h2}, '{1'b1,16'hbee8,16'h0067,2'h1}, '{1'b0,16'hbee8,16'h0567,2'h3},
      '{1'b0,16'h46e8,16'hffff,2'h3}, '{1'b1,16'h03d4,16'h0038,2'h3}, '{1'b1,16'h03d5,16'h0000,2'h3}};

   // ****************************************
   // Clock, design and host
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   ext_reg_decode i_ext_reg_decode (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .io_req(io_req),
      .io_rsp(io_rsp), .strap_pins(strap_pins), .sense_pins(sense_pins), .engine_status(engine_status),
      .subsystem_status(subsystem_status), .color_mode(color_mode), .engine_enable(engine_enable),
      .misc_output(misc_output), .video_subsystem_enable(video_subsystem_enable),
      .subsystem_control(subsystem_control), .advanced_function_control(advanced_function_control),
      .drawing_command(drawing_command), .drawing_command_stb(drawing_command_stb),
      .pixel_transfer(pixel_transfer), .pixel_transfer_stb(pixel_transfer_stb));
   host_model host (.core_clk(core_clk), .io_rsp(io_rsp), .io_req(io_req));

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard; the whole run needs far fewer cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      wrap_up();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      repeat (5) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (8) @(negedge core_clk); // Straps settle before idx 36/37 are read
      foreach (rows[i]) begin
         if (rows[i].w) host.io_wr(rows[i].a, rows[i].d, rows[i].be);
         else begin
            host.io_rd(rows[i].a, q, v);
            check(q, rows[i].d);
            check({15'h0000, v}, 16'h0001);
         end
      end
      host.io_rd(16'h03d5, q, v);
      check(q, 16'h0000);
      host.io_wr(16'h03d4, 16'h0031, 2'h3);
      host.io_rd(16'h03d5, q, v);
      check(q, 16'h0000);
      $display("test table done");
      // Engine writes with word and byte lanes, engine still enabled
      host.io_wr(16'h9ae8, 16'h1234, 2'h3);
      check({15'h0000, drawing_command_stb}, 16'h0001);
      check(drawing_command, 16'h1234);
      host.io_wr(16'h42e8, 16'habcd, 2'h3);
      check(subsystem_control, 16'habcd);
      host.io_wr(16'h46e8, 16'h0008, 2'h3);
      check({8'h00, video_subsystem_enable}, 16'h0008);
      host.io_wr(16'h4ae8, 16'h5500, 2'h2);
      host.io_wr(16'h4ae8, 16'h00aa, 2'h1);
      check(advanced_function_control, 16'h55aa);
      host.io_wr(16'he2e8, 16'h3c5a, 2'h3);
      check({15'h0000, pixel_transfer_stb}, 16'h0001);
      check(pixel_transfer, 16'h3c5a);
      // A write while the clock enable is low must not land
      clk_en = 1'b0;
      host.io_wr(16'h46e8, 16'h0033, 2'h3);
      check({8'h00, video_subsystem_enable}, 16'h0008);
      clk_en = 1'b1;
      $display("test engine writes done");
      // Second reset mid-run relocks and clears mode state
      @(negedge core_clk);
      rst_b = 1'b0;
      @(negedge core_clk);
      check({13'h0000, engine_enable, color_mode, misc_output[0]}, 16'h0000);
      rst_b = 1'b1;
      repeat (8) @(negedge core_clk);
      host.io_wr(16'h03b4, 16'h0031, 2'h3);
      host.io_rd(16'h03b5, q, v);
      check(q, 16'h0000);
      $display("test reset done");
      wrap_up();
   end
endmodule // tb_top
